// ---- testbench/gcbs_link_master.sv ----
// Link master model: sends address and data bytes on a link clock of its own.
// Assumes the caller waits for each word task to return before the next one.
`timescale 1ns/1ns
`default_nettype none
module gcbs_link_master (
    output var logic link_clk_o,
    output var logic addr_valid_o,
    output var gcbs_pkg::gcbs_addr_t addr_o,
    output var logic byte_valid_o,
    output var logic [7:0] byte_o
);
    import gcbs_pkg::*;

    logic run = 1'b1;

    // ----------------------------------------------------------------
    // Link clock
    // ----------------------------------------------------------------
    // Stands low between frames; the 7 ns start keeps it off the system negedges
    initial begin
        link_clk_o = 1'b0;
        addr_valid_o = 1'b0;
        addr_o = '0;
        byte_valid_o = 1'b0;
        byte_o = '0;
        #7;
        forever #16 link_clk_o = run ? ~link_clk_o : 1'b0;
    end

    // ----------------------------------------------------------------
    // Word transfer
    // ----------------------------------------------------------------
    // Address, then top byte, then low byte; released lines show the inverse
    task automatic write_word(input gcbs_addr_t a, input logic [1:0] c, input gcbs_code_t d);
        run = 1'b1;
        @(posedge link_clk_o) #1;
        addr_valid_o = 1'b1;
        addr_o = a;
        @(posedge link_clk_o) #1;
        addr_valid_o = 1'b0;
        addr_o = ~a;
        byte_valid_o = 1'b1;
        byte_o = {c, 4'h9, d[9:8]};
        @(posedge link_clk_o) #1;
        byte_o = d[7:0];
        @(posedge link_clk_o) #1;
        byte_valid_o = 1'b0;
        byte_o = ~d[7:0];
        // Two spare cycles give the minimum spacing between words
        repeat (2) @(posedge link_clk_o);
        run = 1'b0;
    endtask : write_word
endmodule : gcbs_link_master
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the gamma code bank store.
// Assumes the link master model and the design package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import gcbs_pkg::*;

    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic bank = 1'b0;
    logic supply_ok = 1'b1;
    logic hot = 1'b0;
    logic cooled = 1'b0;
    logic link_clk, addr_valid, byte_valid, bank_act, out_en;
    logic [7:0] lk_byte;
    gcbs_addr_t addr;
    gcbs_set_t active_set;
    gcbs_code_t ref_code;
    int error_cnt = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'h9351;
    gcbs_code_t hold [64];
    gcbs_code_t dac [64];

    always #5 clk_sys_i = ~clk_sys_i;

    gcbs_link_master gcbs_link_master_i (.link_clk_o(link_clk), .addr_valid_o(addr_valid),
        .addr_o(addr), .byte_valid_o(byte_valid), .byte_o(lk_byte));

    gcbs_store gcbs_store_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link_clk_i(link_clk),
        .link_addr_valid_i(addr_valid), .link_addr_i(addr), .link_byte_valid_i(byte_valid),
        .link_byte_i(lk_byte), .bank_select_input_i(bank), .digital_supply_ok_i(supply_ok),
        .over_temp_i(hot), .temp_cooled_i(cooled), .active_set_o(active_set),
        .reference_code_o(ref_code), .bank_active_o(bank_act), .outputs_enable_o(out_en));

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic valid_addr(input gcbs_addr_t a);
        return a <= 6'h0b || a == 6'h12 || a == 6'h18 || a == 6'h19 || a == 6'h1f
            || (a >= 6'h20 && a <= 6'h2e);
    endfunction : valid_addr

    // Set one sits at 0x00, set two at 0x20; limits live at scattered places
    function automatic gcbs_set_t exp_set(input logic b);
        gcbs_set_t s;
        for (int i = 0; i < GCBS_GAMMA_N; i++) begin
            s.gamma[i] = dac[(b ? 32 : 0) + i];
        end
        s.backplane = dac[b ? 6'h2c : 6'h12];
        s.min_limit = dac[b ? 6'h2d : 6'h18];
        s.max_limit = dac[b ? 6'h2e : 6'h19];
        return s;
    endfunction : exp_set

    task automatic model_rst();
        for (int a = 0; a < 64; a++) begin
            hold[a] = valid_addr(6'(a)) ? 10'h200 : 10'h000;
        end
        hold[6'h18] = 10'h000;
        hold[6'h2d] = 10'h000;
        hold[6'h19] = 10'h3ff;
        hold[6'h2e] = 10'h3ff;
        dac = hold;
    endtask : model_rst

    // ----------------------------------------------------------------
    // Compare tasks
    // ----------------------------------------------------------------
    task automatic chk_set(input gcbs_set_t got, input gcbs_set_t exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t code set %h expected %h", $time, got, exp);
        end
    endtask : chk_set

    task automatic chk_code(input gcbs_code_t got, input gcbs_code_t exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t code %h expected %h", $time, got, exp);
        end
    endtask : chk_code

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // ----------------------------------------------------------------
    // Stimulus tasks
    // ----------------------------------------------------------------
    // Watches every cycle so that a half-applied set shows up as a mixture
    task automatic wr_chk(input gcbs_addr_t a, input logic [1:0] c, input gcbs_code_t d);
        gcbs_set_t old_s;
        gcbs_set_t new_s;
        logic mixed;
        old_s = exp_set(bank);
        if (supply_ok && c != GCBS_WC_LOAD && valid_addr(a)) hold[a] = d;
        if (supply_ok && (c == GCBS_WC_HOLD_LOAD || c == GCBS_WC_LOAD)) dac = hold;
        new_s = exp_set(bank);
        mixed = 1'b0;
        fork
            gcbs_link_master_i.write_word(a, c, d);
            repeat (30) begin
                @(negedge clk_sys_i);
                mixed |= (active_set !== old_s && active_set !== new_s);
            end
        join
        chk_bit(mixed, 1'b0);
        chk_set(active_set, new_s);
        chk_code(ref_code, dac[6'h1f]);
    endtask : wr_chk

    task automatic set_bank(input logic b);
        logic mixed;
        mixed = 1'b0;
        @(negedge clk_sys_i);
        bank = b;
        repeat (6) begin
            @(negedge clk_sys_i);
            mixed |= (active_set !== exp_set(bank_act));
        end
        chk_bit(mixed, 1'b0);
        chk_bit(bank_act, b);
        chk_set(active_set, exp_set(b));
    endtask : set_bank

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        gcbs_addr_t a;
        logic [14:0] th;
        // The all-low row after the hot row checks that outputs stay off until cooled
        th = {3'b100, 3'b000, 3'b110, 3'b011, 3'b001};
        model_rst();
        repeat (8) @(negedge clk_sys_i);
        reset_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk_set(active_set, exp_set(1'b0));
        chk_code(ref_code, 10'h200);
        chk_bit(out_en, 1'b1);
        $display("test reset values done");
        wr_chk(6'h05, GCBS_WC_HOLD, 10'h155);
        wr_chk(6'h2c, GCBS_WC_RSVD, 10'h0aa);
        wr_chk(6'h00, GCBS_WC_LOAD, 10'h3ff);
        set_bank(1'b1);
        wr_chk(6'h1f, GCBS_WC_HOLD_LOAD, 10'h3ff);
        wr_chk(6'h1f, GCBS_WC_HOLD_LOAD, 10'h000);
        wr_chk(6'h0c, GCBS_WC_HOLD, 10'h123);
        wr_chk(6'h12, GCBS_WC_LOAD, 10'h000);
        $display("test hold and load done");
        // Reserved places only ever get the plain store code
        for (int n = 0; n < 40; n++) begin
            r = xs();
            if (r[20]) set_bank(r[21]);
            a = 6'(r[15:10] % 6'd47);
            wr_chk(a, valid_addr(a) ? r[9:8] : GCBS_WC_HOLD, r[31:22]);
        end
        $display("test random writes done");
        // Rows of hot, cooled and the expected enable
        for (int k = 4; k >= 0; k--) begin
            @(negedge clk_sys_i);
            {hot, cooled} = th[3*k+1 +: 2];
            repeat (4) @(negedge clk_sys_i);
            chk_bit(out_en, th[3*k]);
        end
        $display("test thermal done");
        @(negedge clk_sys_i);
        supply_ok = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        model_rst();
        chk_set(active_set, exp_set(bank));
        wr_chk(6'h1f, GCBS_WC_HOLD_LOAD, 10'h155);
        supply_ok = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        wr_chk(6'h20, GCBS_WC_HOLD_LOAD, 10'h2aa);
        $display("test supply drop done");
        finish_test();
    end

    // Expected run is near 1,700 cycles; this limit is far beyond it
    initial begin
        #500000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule : testbench
`default_nettype wire

// ---- verilog/gcbs_pkg.sv ----
// Shared constants and types for the gamma code bank store.
// Assumes a single 10-bit code width for every stored word.
package gcbs_pkg;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int GCBS_CODE_W = 10;
    localparam int GCBS_GAMMA_N = 12;
    localparam int GCBS_ADDR_W = 6;
    localparam int GCBS_BYTE_W = 8;
    localparam int GCBS_SET_N = 2;
    localparam int GCBS_PIN_N = 5;

    typedef logic [GCBS_CODE_W-1:0] gcbs_code_t;
    typedef logic [GCBS_ADDR_W-1:0] gcbs_addr_t;

    // One complete code set: twelve gamma codes, backplane code and its limits
    typedef struct packed {
        gcbs_code_t [GCBS_GAMMA_N-1:0] gamma;
        gcbs_code_t backplane;
        gcbs_code_t min_limit;
        gcbs_code_t max_limit;
    } gcbs_set_t;

    // One assembled write word as it crosses from the link
    typedef struct packed {
        gcbs_addr_t addr;
        logic [1:0] ctrl;
        gcbs_code_t data;
    } gcbs_wr_t;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam gcbs_addr_t GCBS_A_GAMMA1_BASE = 6'h00;
    localparam gcbs_addr_t GCBS_A_BACKPLANE1 = 6'h12;
    localparam gcbs_addr_t GCBS_A_MIN1 = 6'h18;
    localparam gcbs_addr_t GCBS_A_MAX1 = 6'h19;
    localparam gcbs_addr_t GCBS_A_REF = 6'h1f;
    localparam gcbs_addr_t GCBS_A_GAMMA2_BASE = 6'h20;
    localparam gcbs_addr_t GCBS_A_BACKPLANE2 = 6'h2c;
    localparam gcbs_addr_t GCBS_A_MIN2 = 6'h2d;
    localparam gcbs_addr_t GCBS_A_MAX2 = 6'h2e;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam gcbs_code_t GCBS_CODE_RST = 10'h200;
    localparam gcbs_code_t GCBS_MIN_RST = 10'h000;
    localparam gcbs_code_t GCBS_MAX_RST = 10'h3ff;
    localparam gcbs_set_t GCBS_SET_RST = '{
        gamma: {GCBS_GAMMA_N{GCBS_CODE_RST}},
        backplane: GCBS_CODE_RST,
        min_limit: GCBS_MIN_RST,
        max_limit: GCBS_MAX_RST
    };

    // ------------------------------------------------------------
    // Write control codes carried in the two top bits of a word
    // ------------------------------------------------------------
    localparam logic [1:0] GCBS_WC_HOLD = 2'h0;
    localparam logic [1:0] GCBS_WC_HOLD_LOAD = 2'h1;
    localparam logic [1:0] GCBS_WC_LOAD = 2'h2;
    localparam logic [1:0] GCBS_WC_RSVD = 2'h3;
    localparam int GCBS_CTRL_HI = 7;
    localparam int GCBS_CTRL_LO = 6;
    localparam int GCBS_MSB_DATA_W = GCBS_CODE_W - GCBS_BYTE_W;

    // Link byte pairing states, one-hot
    typedef enum logic [2:0] {
        GCBS_LK_ADDR = 3'h1,
        GCBS_LK_MSB = 3'h2,
        GCBS_LK_LSB = 3'h4
    } gcbs_link_st_t;

endpackage : gcbs_pkg

// ---- verilog/gcbs_store.sv ----
// Gamma code bank store: holding and converter registers for two code sets.
// Assumes a serial front end on link_clk_i delivering address and data bytes.
// Functional notes
// RULE1: two sets plus one shared reference code
// RULE2: 10-bit words, two bytes per access
// RULE3: master fills holding registers before loading
// RULE4: holding to converter copy is fully parallel
// RULE5: bank select picks the applied set
// RULE6: codes by bus, set switching by pin
// RULE7: reference code spans 0 to 1023
// RULE8: converter codes span 0 to 1023 unclamped
// RULE9: registers held at reset until supply good
// RULE10: over-temperature disables outputs, re-enable after cooling
// RULE11: low selects first set, high second
// RULE12: store low ten bits, top two control
// RULE13: codes reset to mid-scale value
// RULE14: bank select synchronised before steering
`timescale 1ns/1ns
`default_nettype none
module gcbs_store (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic link_addr_valid_i,
    input wire gcbs_pkg::gcbs_addr_t link_addr_i,
    input wire logic link_byte_valid_i,
    input wire logic [gcbs_pkg::GCBS_BYTE_W-1:0] link_byte_i,
    input wire logic bank_select_input_i,
    input wire logic digital_supply_ok_i,
    input wire logic over_temp_i,
    input wire logic temp_cooled_i,
    output gcbs_pkg::gcbs_set_t active_set_o,
    output gcbs_pkg::gcbs_code_t reference_code_o,
    output logic bank_active_o,
    output logic outputs_enable_o
);
    import gcbs_pkg::*;

    // ------------------------------------------------------------
    // Link domain: pair address and two bytes into one word
    // ------------------------------------------------------------
    gcbs_link_st_t lk_st_r, lk_st_nxt;
    gcbs_addr_t lk_addr_r, lk_addr_nxt;
    logic [GCBS_BYTE_W-1:0] lk_msb_r, lk_msb_nxt;
    gcbs_wr_t lk_wr_r, lk_wr_nxt;
    logic lk_tog_r, lk_tog_nxt;

    // Byte pairing, most significant byte first; a new address restarts
    always_comb begin
        lk_st_nxt = lk_st_r;
        lk_addr_nxt = lk_addr_r;
        lk_msb_nxt = lk_msb_r;
        lk_wr_nxt = lk_wr_r;
        lk_tog_nxt = lk_tog_r;
        if (link_addr_valid_i) begin
            lk_addr_nxt = link_addr_i;
            lk_st_nxt = GCBS_LK_MSB;
        end else if (link_byte_valid_i) begin
            case (lk_st_r)
                GCBS_LK_MSB: begin
                    lk_msb_nxt = link_byte_i;
                    lk_st_nxt = GCBS_LK_LSB;
                end
                GCBS_LK_LSB: begin
                    lk_wr_nxt.addr = lk_addr_r; // RULE2
                    lk_wr_nxt.ctrl = lk_msb_r[GCBS_CTRL_HI:GCBS_CTRL_LO]; // RULE12
                    lk_wr_nxt.data = {lk_msb_r[GCBS_MSB_DATA_W-1:0], link_byte_i}; // RULE12
                    lk_tog_nxt = ~lk_tog_r;
                    lk_st_nxt = GCBS_LK_ADDR;
                end
                GCBS_LK_ADDR: lk_st_nxt = GCBS_LK_ADDR;
                default: lk_st_nxt = GCBS_LK_ADDR;
            endcase
        end
    end

    // Link registers; the word stays put until the next pair completes
    always_ff @(posedge link_clk_i or posedge reset_i) begin
        if (reset_i) begin
            lk_st_r <= GCBS_LK_ADDR;
            lk_addr_r <= '0;
            lk_msb_r <= '0;
            lk_wr_r <= '0;
            lk_tog_r <= 1'b0;
        end else begin
            lk_st_r <= lk_st_nxt;
            lk_addr_r <= lk_addr_nxt;
            lk_msb_r <= lk_msb_nxt;
            lk_wr_r <= lk_wr_nxt;
            lk_tog_r <= lk_tog_nxt;
        end
    end

    // ------------------------------------------------------------
    // Crossing of pins and the write toggle into the system clock
    // ------------------------------------------------------------
    logic [GCBS_PIN_N-1:0] pins_s;
    logic bank_s, supply_s, over_s, cooled_s, tog_s;

    gcbs_sync #(
        .W(GCBS_PIN_N)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i({bank_select_input_i, digital_supply_ok_i, over_temp_i, temp_cooled_i, lk_tog_r}),
        .q_o(pins_s)
    );
    assign {bank_s, supply_s, over_s, cooled_s, tog_s} = pins_s; // RULE14

    // ------------------------------------------------------------
    // System domain: holding and converter registers
    // ------------------------------------------------------------
    gcbs_set_t [GCBS_SET_N-1:0] hold_r, hold_nxt, dac_r, dac_nxt; // RULE1
    gcbs_code_t ref_hold_r, ref_hold_nxt, dac_ref_r, dac_ref_nxt; // RULE1
    logic tog_seen_r, tog_seen_nxt;
    logic apply, load;
    gcbs_wr_t wr;

    // The word is sampled only after its toggle has crossed, so it is stable
    assign apply = tog_s ^ tog_seen_r;
    assign wr = lk_wr_r;

    // Decode a write, then optionally copy every holding register at once
    always_comb begin
        hold_nxt = hold_r;
        ref_hold_nxt = ref_hold_r;
        dac_nxt = dac_r;
        dac_ref_nxt = dac_ref_r;
        tog_seen_nxt = tog_s;
        if (apply && wr.ctrl != GCBS_WC_LOAD) begin
            for (int i = 0; i < GCBS_GAMMA_N; i++) begin
                if (wr.addr == GCBS_A_GAMMA1_BASE + GCBS_ADDR_W'(i)) begin
                    hold_nxt[0].gamma[i] = wr.data; // RULE3
                end
                if (wr.addr == GCBS_A_GAMMA2_BASE + GCBS_ADDR_W'(i)) begin
                    hold_nxt[1].gamma[i] = wr.data; // RULE3
                end
            end
            case (wr.addr)
                GCBS_A_BACKPLANE1: hold_nxt[0].backplane = wr.data;
                GCBS_A_MIN1: hold_nxt[0].min_limit = wr.data;
                GCBS_A_MAX1: hold_nxt[0].max_limit = wr.data;
                GCBS_A_BACKPLANE2: hold_nxt[1].backplane = wr.data;
                GCBS_A_MIN2: hold_nxt[1].min_limit = wr.data;
                GCBS_A_MAX2: hold_nxt[1].max_limit = wr.data;
                GCBS_A_REF: ref_hold_nxt = wr.data; // RULE7
                default: ref_hold_nxt = ref_hold_r; // Reserved: ignored
            endcase
        end
        load = apply && (wr.ctrl == GCBS_WC_HOLD_LOAD || wr.ctrl == GCBS_WC_LOAD); // RULE12
        if (load) begin
            dac_nxt = hold_nxt; // RULE4
            dac_ref_nxt = ref_hold_nxt; // RULE4
        end
        // Supply not yet good: every holding and converter register forced to its reset value
        if (!supply_s) begin
            hold_nxt = {GCBS_SET_N{GCBS_SET_RST}}; // RULE9
            dac_nxt = {GCBS_SET_N{GCBS_SET_RST}}; // RULE13
            ref_hold_nxt = GCBS_CODE_RST; // RULE13
            dac_ref_nxt = GCBS_CODE_RST; // RULE9
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hold_r <= {GCBS_SET_N{GCBS_SET_RST}};
            dac_r <= {GCBS_SET_N{GCBS_SET_RST}};
            ref_hold_r <= GCBS_CODE_RST;
            dac_ref_r <= GCBS_CODE_RST;
            tog_seen_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            dac_r <= dac_nxt;
            ref_hold_r <= ref_hold_nxt;
            dac_ref_r <= dac_ref_nxt;
            tog_seen_r <= tog_seen_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output steering and thermal gate
    // ------------------------------------------------------------
    gcbs_set_t out_set_r, out_set_nxt;
    gcbs_code_t out_ref_r, out_ref_nxt;
    logic out_bank_r, out_bank_nxt, en_r, en_nxt;

    // One synchronised bit picks the whole set, so no mixed set appears
    always_comb begin
        out_set_nxt = dac_r[bank_s]; // RULE5 RULE11 RULE6
        out_ref_nxt = dac_ref_r; // RULE8
        out_bank_nxt = bank_s;
        en_nxt = en_r;
        if (over_s) begin
            en_nxt = 1'b0; // RULE10
        end else if (cooled_s) begin
            en_nxt = 1'b1; // RULE10
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            out_set_r <= GCBS_SET_RST;
            out_ref_r <= GCBS_CODE_RST;
            out_bank_r <= 1'b0;
            en_r <= 1'b1;
        end else begin
            out_set_r <= out_set_nxt;
            out_ref_r <= out_ref_nxt;
            out_bank_r <= out_bank_nxt;
            en_r <= en_nxt;
        end
    end

    assign active_set_o = out_set_r;
    assign reference_code_o = out_ref_r;
    assign bank_active_o = out_bank_r;
    assign outputs_enable_o = en_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_bank_high;
        @(posedge clk_sys_i) disable iff (reset_i)
        bank_s |=> active_set_o == $past(dac_r[1]) && bank_active_o;
    endproperty
    a_bank_high: assert property (p_bank_high) else $error("set two not applied"); // RULE11
    property p_bank_low;
        @(posedge clk_sys_i) disable iff (reset_i)
        !bank_s |=> active_set_o == $past(dac_r[0]) && !bank_active_o;
    endproperty
    a_bank_low: assert property (p_bank_low) else $error("set one not applied"); // RULE5
    property p_load_parallel;
        @(posedge clk_sys_i) disable iff (reset_i)
        supply_s && apply && wr.ctrl == GCBS_WC_HOLD_LOAD |=> dac_r == hold_r && dac_ref_r == ref_hold_r;
    endproperty
    a_load_parallel: assert property (p_load_parallel) else $error("load not parallel"); // RULE4
    property p_hold_only;
        @(posedge clk_sys_i) disable iff (reset_i)
        supply_s && apply && wr.ctrl == GCBS_WC_HOLD ##1 supply_s |-> $stable(dac_r);
    endproperty
    a_hold_only: assert property (p_hold_only) else $error("converter changed on hold write"); // RULE3
    property p_ref_low_bits;
        @(posedge clk_sys_i) disable iff (reset_i)
        supply_s && apply && wr.ctrl != GCBS_WC_LOAD && wr.addr == GCBS_A_REF
        |=> ref_hold_r == $past(wr.data);
    endproperty
    a_ref_low_bits: assert property (p_ref_low_bits) else $error("reference word not stored"); // RULE12
    property p_por_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        !supply_s |=> dac_ref_r == GCBS_CODE_RST && dac_r[0] == GCBS_SET_RST && dac_r[1] == GCBS_SET_RST;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("registers not held at reset"); // RULE9
    property p_thermal_off;
        @(posedge clk_sys_i) disable iff (reset_i)
        over_s |=> !outputs_enable_o;
    endproperty
    a_thermal_off: assert property (p_thermal_off) else $error("outputs not disabled when hot"); // RULE10
    property p_thermal_on;
        @(posedge clk_sys_i) disable iff (reset_i)
        !over_s && cooled_s |=> outputs_enable_o;
    endproperty
    a_thermal_on: assert property (p_thermal_on) else $error("outputs not re-enabled"); // RULE10
    property p_ref_out;
        @(posedge clk_sys_i) disable iff (reset_i)
        $changed(dac_ref_r) |=> reference_code_o == $past(dac_ref_r);
    endproperty
    a_ref_out: assert property (p_ref_out) else $error("reference code not passed through"); // RULE8
    property p_pair;
        @(posedge link_clk_i) disable iff (reset_i)
        lk_st_r == GCBS_LK_LSB && link_byte_valid_i && !link_addr_valid_i |=> $changed(lk_tog_r);
    endproperty
    a_pair: assert property (p_pair) else $error("two bytes did not make a word"); // RULE2
    property p_pin_only;
        @(posedge clk_sys_i) disable iff (reset_i)
        !apply && supply_s |=> $stable(dac_r);
    endproperty
    a_pin_only: assert property (p_pin_only) else $error("codes changed without a write"); // RULE6

    c_load: cover property (@(posedge clk_sys_i) disable iff (reset_i) load && supply_s);
    c_switch: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(bank_active_o));
    c_thermal: cover property (@(posedge clk_sys_i) disable iff (reset_i) $fell(outputs_enable_o));
    c_hold: cover property (@(posedge clk_sys_i) disable iff (reset_i) apply && wr.ctrl == GCBS_WC_HOLD);

endmodule : gcbs_store
`default_nettype wire

// ---- verilog/gcbs_sync.sv ----
// Two-flop level synchroniser, one per bit.
// Assumes each bit is a slow level or a toggle, never a multi-bit word.
`timescale 1ns/1ns
`default_nettype none
module gcbs_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // First stage is read only by the second stage
    always_comb begin
        meta_nxt = d_i;
        q_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule : gcbs_sync
`default_nettype wire
